// ### rtl/axis_status_error_cause.v
// extended status word and error-cause word of one motion axis
// assumes the stop logic, comparators and inputs share clk; external
// sensor pins arrive asynchronous and are synchronised here
//
// Function
// - state codes 0000 stopped, 0001-0110 waits, 0111 backlash correction.
// - state codes 1000-1111 pulser wait, feeds, ramps, settle wait, other.
// - status bit 4 shows direction, 1 means negative.
// - status bits 5-9 mirror start, stop, emergency, trigger, clear output.
// - status bits 10-16 mirror index, jogs, reset, capture, slowdown, settled.
// - status bits 18-19 show comparator 5 pre-register occupancy.
// - status bits 20-21 show operation pre-register occupancy; others zero.
// - an error event sets its matching cause bit.
// - clear mode 0: read clears cause word; writing ones also clears.
// - clear mode 1: reads keep bits; writing ones clears them.
// - cause bits 0-4 flag stops by comparators 1 to 5.
// - cause bits 5-9 flag stops by limits, alarm, stop, emergency.
// - cause bit 10 flags slowdown stop; bit 11 reads zero.
// - bit 12 interpolation data error, bit 13 partner axis error stop.
// - bit 14 pulser buffer overflow, bit 15 interpolation counter overrange.
// - bits 16-17 encoder and pulser phase errors; bits 18-31 zero.
// - linear mode 1 started on one axis raises data error.
// - circular start on one, three or four axes raises data error.
// - circular start with arc center at zero raises data error.
// - linear mode 2 start with zero total length raises data error.
// - synced circular mode errors if fourth axis fails or finishes early.
`timescale 1ns/1ps
`include "axis_status_defs.vh"

module axis_status_error_cause #(
  parameter PIN_COUNT = 13
) (
  input wire clk,
  input wire resetn,
  input wire [3:0] addr,
  input wire [31:0] wrData,
  input wire wrStrobe,
  input wire rdStrobe,
  output reg [31:0] rdData,
  input wire [3:0] operationState,
  input wire directionFlag,
  input wire sharedStartLine,
  input wire sharedStopLine,
  input wire sharedEmergencyLine,
  input wire positionStartTrigger,
  input wire errorCounterClearOutput,
  input wire encoderIndex,
  input wire jogPlusLine,
  input wire jogMinusLine,
  input wire countResetLine,
  input wire countCaptureLine,
  input wire slowdownLine,
  input wire positionSettledSignal,
  input wire [1:0] cmp5PreregOccupancy,
  input wire [1:0] opPreregOccupancy,
  input wire [4:0] cmpStopEvent,
  input wire plusLimitStopEvent,
  input wire minusLimitStopEvent,
  input wire alarmStopEvent,
  input wire sharedStopEvent,
  input wire emergencyStopEvent,
  input wire slowdownStopEvent,
  input wire partnerAxisErrorEvent,
  input wire pulserOverflowEvent,
  input wire interpOverrangeEvent,
  input wire encoderPhaseErrorEvent,
  input wire pulserPhaseErrorEvent,
  input wire startCommand,
  input wire [7:0] operationTypeCode,
  input wire [2:0] interpAxisCount,
  input wire arcCenterZero,
  input wire interpLengthZero,
  input wire fourthAxisNoResponse,
  input wire fourthAxisEarlyDone,
  output wire interpDataError,
  output wire causePending
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three stages, change taken when stages 2 and 3 agree

  wire [PIN_COUNT-1:0] pinRaw;
  reg [PIN_COUNT-1:0] sync1_q;
  reg [PIN_COUNT-1:0] sync2_q;
  reg [PIN_COUNT-1:0] sync3_q;
  reg [PIN_COUNT-1:0] pinState_q;

  // active-low shared lines are inverted so that 1 means ON
  assign pinRaw = {positionSettledSignal, slowdownLine, countCaptureLine,
                   countResetLine, jogMinusLine, jogPlusLine, encoderIndex,
                   errorCounterClearOutput, positionStartTrigger,
                   ~sharedEmergencyLine, ~sharedStopLine, ~sharedStartLine,
                   1'b0};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi = gi + 1) begin : pinSync
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
          sync3_q[gi] <= 1'b0;
          pinState_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= pinRaw[gi];
          sync2_q[gi] <= sync1_q[gi];
          sync3_q[gi] <= sync2_q[gi];
          if (sync2_q[gi] == sync3_q[gi]) begin
            pinState_q[gi] <= sync3_q[gi];
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // extended status word

  wire [31:0] extStatus;
  assign extStatus = {10'h000,
                      opPreregOccupancy,
                      cmp5PreregOccupancy,
                      1'b0,
                      pinState_q[12:6],
                      pinState_q[5:1],
                      directionFlag,
                      operationState};

  ////////////////////////////////////////////////////////////////////////////
  // interpolation start check

  reg linOne;
  reg linTwo;
  reg circ;
  reg circSync;
  reg startError;

  always @* begin
    linOne = 1'b0;
    linTwo = 1'b0;
    circ = 1'b0;
    circSync = 1'b0;
    case (operationTypeCode)
      `MOD_LIN1_A, `MOD_LIN1_B, `MOD_LIN1_C, `MOD_LIN1_D: linOne = 1'b1;
      `MOD_LIN2_A, `MOD_LIN2_B, `MOD_LIN2_C, `MOD_LIN2_D: linTwo = 1'b1;
      `MOD_CIRC_A, `MOD_CIRC_B, `MOD_CIRC_C, `MOD_CIRC_D: circ = 1'b1;
      `MOD_CIRC_SYNC_A, `MOD_CIRC_SYNC_B: begin
        circ = 1'b1;
        circSync = 1'b1;
      end
      default: circ = 1'b0;
    endcase
    startError = startCommand &
                 ((linOne & (interpAxisCount == 3'd1)) |
                  (circ & (interpAxisCount != 3'd2)) |
                  (circ & arcCenterZero) |
                  (linTwo & interpLengthZero));
  end

  // sync-circular watch: held from an error-free start until the axis is back in the stopped state
  reg syncActive_q;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      syncActive_q <= 1'b0;
    end else if (startCommand) begin
      syncActive_q <= circSync & ~startError;
    end else if (operationState == `ST_STOPPED) begin
      syncActive_q <= 1'b0;
    end
  end

  assign interpDataError = startError |
                           (syncActive_q & (fourthAxisNoResponse |
                                            fourthAxisEarlyDone));

  ////////////////////////////////////////////////////////////////////////////
  // error-cause word and clear mode

  reg [31:0] errCause_q;
  reg [31:0] errCause_d;
  reg clearMode_q;
  wire [31:0] errSet;
  wire [31:0] errClr;
  wire readCause;
  wire writeCause;

  // spare bits never set
  assign errSet[31:18] = 14'h0000;
  // phase errors report without stopping the drive
  assign errSet[17] = pulserPhaseErrorEvent;
  assign errSet[16] = encoderPhaseErrorEvent;
  assign errSet[15] = interpOverrangeEvent;
  assign errSet[14] = pulserOverflowEvent;
  assign errSet[13] = partnerAxisErrorEvent;
  assign errSet[12] = interpDataError;
  assign errSet[11] = 1'b0;
  assign errSet[10] = slowdownStopEvent;
  assign errSet[9] = emergencyStopEvent;
  assign errSet[8] = sharedStopEvent;
  assign errSet[7] = alarmStopEvent;
  assign errSet[6] = minusLimitStopEvent;
  assign errSet[5] = plusLimitStopEvent;
  // comparators 1 and 2 act as soft limits
  assign errSet[4:0] = cmpStopEvent;

  assign readCause = rdStrobe & (addr == `ADDR_ERR_CAUSE);
  assign writeCause = wrStrobe & (addr == `ADDR_ERR_CAUSE);
  assign errClr = ((readCause & ~clearMode_q) ? 32'hFFFFFFFF : 32'h00000000) |
                  (writeCause ? wrData : 32'h00000000);

  always @* begin
    errCause_d = (errCause_q & ~errClr) | errSet;
    errCause_d[`ERR_BIT_RESERVED] = 1'b0;
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      errCause_q <= `ERR_CAUSE_RESET;
      clearMode_q <= `CLEAR_MODE_RESET;
    end else begin
      errCause_q <= errCause_d;
      if (wrStrobe && addr == `ADDR_CLEAR_MODE) begin
        clearMode_q <= wrData[0];
      end
    end
  end

  assign causePending = |errCause_q;

  ////////////////////////////////////////////////////////////////////////////
  // read port: data one cycle after the strobe, zero otherwise

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdData <= 32'h00000000;
    end else if (rdStrobe) begin
      case (addr)
        `ADDR_EXT_STATUS: rdData <= extStatus;
        `ADDR_ERR_CAUSE: rdData <= errCause_q;
        `ADDR_CLEAR_MODE: rdData <= {31'h00000000, clearMode_q};
        default: rdData <= 32'h00000000;
      endcase
    end else begin
      rdData <= 32'h00000000;
    end
  end

endmodule // axis_status_error_cause

// ### rtl/axis_status_defs.vh
// offsets, field positions and reset values of the axis status block
// included by axis_status_error_cause.v
`ifndef AXIS_STATUS_DEFS_VH
`define AXIS_STATUS_DEFS_VH

`define ADDR_EXT_STATUS 4'h0
`define ADDR_ERR_CAUSE 4'h1
`define ADDR_CLEAR_MODE 4'h2
`define ERR_CAUSE_RESET 32'h00000000
`define CLEAR_MODE_RESET 1'b0

`define ST_STOPPED 4'h0
`define ST_BACKLASH 4'h7
`define ST_PULSER_WAIT 4'h8
`define ST_OTHER_START 4'hF

`define ERR_BIT_SLOWDOWN 10
`define ERR_BIT_RESERVED 11
`define ERR_BIT_INTERP_DATA 12

`define MOD_LIN1_A 8'h60
`define MOD_LIN1_B 8'h61
`define MOD_LIN1_C 8'h68
`define MOD_LIN1_D 8'h69
`define MOD_LIN2_A 8'h62
`define MOD_LIN2_B 8'h63
`define MOD_LIN2_C 8'h6A
`define MOD_LIN2_D 8'h6B
`define MOD_CIRC_A 8'h64
`define MOD_CIRC_B 8'h65
`define MOD_CIRC_SYNC_A 8'h66
`define MOD_CIRC_SYNC_B 8'h67
`define MOD_CIRC_C 8'h6C
`define MOD_CIRC_D 8'h6D

`endif

// ### sim/axis_status_error_cause_properties.sv
// concurrent checks on the axis status and error-cause block ports
// assumes one clock domain and the registered one-cycle read data
`timescale 1ns/1ps
module axis_status_error_cause_properties (
  input wire clk,
  input wire resetn,
  input wire [3:0] addr,
  input wire rdStrobe,
  input wire [31:0] rdData,
  input wire [3:0] operationState,
  input wire directionFlag,
  input wire [1:0] cmp5PreregOccupancy,
  input wire [1:0] opPreregOccupancy,
  input wire [4:0] cmpStopEvent,
  input wire startCommand,
  input wire [7:0] operationTypeCode,
  input wire [2:0] interpAxisCount,
  input wire arcCenterZero,
  input wire interpLengthZero,
  input wire interpDataError,
  input wire causePending
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire lin1 = operationTypeCode inside {8'h60, 8'h61, 8'h68, 8'h69};
  wire lin2 = operationTypeCode inside {8'h62, 8'h63, 8'h6A, 8'h6B};
  wire circ = operationTypeCode inside {[8'h64:8'h67], 8'h6C, 8'h6D};
  ////////////////////////////////////////////////////////////////////////////
  a_status_state: assert property ($past(rdStrobe) && $past(addr) == 4'h0 |->
    rdData[4:0] == {$past(directionFlag), $past(operationState)})
    else $error("status state or direction wrong");
  a_status_prereg: assert property ($past(rdStrobe) && $past(addr) == 4'h0 |->
    rdData[21:18] == {$past(opPreregOccupancy), $past(cmp5PreregOccupancy)})
    else $error("status occupancy wrong");
  a_status_zeros: assert property ($past(rdStrobe) && $past(addr) == 4'h0 |->
    rdData[31:22] == 10'h000 && !rdData[17]) else $error("status spare bits set");
  a_cause_zeros: assert property ($past(rdStrobe) && $past(addr) == 4'h1 |->
    rdData[31:18] == 14'h0000 && !rdData[11]) else $error("cause spare bits set");
  a_lin1_single: assert property (startCommand && lin1 && interpAxisCount == 3'h1
    |-> interpDataError) else $error("linear 1 single axis not flagged");
  a_circ_axes: assert property (startCommand && circ && interpAxisCount != 3'h2
    |-> interpDataError) else $error("circular axis count not flagged");
  a_arc_center: assert property (startCommand && circ && arcCenterZero
    |-> interpDataError) else $error("zero arc center not flagged");
  a_lin2_length: assert property (startCommand && lin2 && interpLengthZero
    |-> interpDataError) else $error("zero total length not flagged");
  a_event_latch: assert property (interpDataError || cmpStopEvent != 5'h00
    |=> causePending) else $error("event did not latch");
endmodule // axis_status_error_cause_properties

bind axis_status_error_cause axis_status_error_cause_properties u_props (.clk, .resetn,
  .addr, .rdStrobe, .rdData, .operationState, .directionFlag, .cmp5PreregOccupancy,
  .opPreregOccupancy, .cmpStopEvent, .startCommand, .operationTypeCode, .interpAxisCount,
  .arcCenterZero, .interpLengthZero, .interpDataError, .causePending);

// ### sim/axis_sensor_model.sv
// pin-level model of the sensor and control inputs of one axis
// onLevel is which inputs are ON; pins change off the clock grid
`timescale 1ns/1ps
module axis_sensor_model (
  input wire [11:0] onLevel,
  output logic [11:0] pin
);
  // shared start, stop and emergency lines are low-active
  initial pin = 12'h007;
  always @(onLevel) pin <= #13 onLevel ^ 12'h007;
endmodule // axis_sensor_model

// ### sim/axis_status_error_cause_bench.sv
// self-checking bench for the axis status and error-cause block
// drives register port, state levels, events; pins via sensor model
`timescale 1ns/1ps
module axis_status_error_cause_bench;
  logic clk = 0, resetn = 0, wrStrobe = 0, rdStrobe = 0, directionFlag = 0, mode = 0;
  logic startCommand = 0, arcCenterZero = 0, interpLengthZero = 0;
  logic fourthAxisNoResponse = 0, fourthAxisEarlyDone = 0;
  logic [3:0] addr = 0, operationState = 0;
  logic [31:0] wrData = 0, m = 0;
  logic [17:0] ev = 0;
  logic [11:0] on = 0, pin;
  logic [1:0] cmp5PreregOccupancy = 0, opPreregOccupancy = 0;
  logic [7:0] operationTypeCode = 0;
  logic [2:0] interpAxisCount = 0;
  wire [31:0] rdData;
  wire interpDataError, causePending;
  integer mismatches = 0, comparisons = 0, seed = 26989, i;
  always #25 clk = ~clk;
  axis_sensor_model u_sensors (.onLevel(on), .pin(pin));
  axis_status_error_cause u_dut (.clk, .resetn, .addr, .wrData, .wrStrobe, .rdStrobe,
    .rdData, .operationState, .directionFlag, .sharedStartLine(pin[0]),
    .sharedStopLine(pin[1]), .sharedEmergencyLine(pin[2]), .positionStartTrigger(pin[3]),
    .errorCounterClearOutput(pin[4]), .encoderIndex(pin[5]), .jogPlusLine(pin[6]),
    .jogMinusLine(pin[7]), .countResetLine(pin[8]), .countCaptureLine(pin[9]),
    .slowdownLine(pin[10]), .positionSettledSignal(pin[11]), .cmp5PreregOccupancy,
    .opPreregOccupancy, .cmpStopEvent(ev[4:0]), .plusLimitStopEvent(ev[5]),
    .minusLimitStopEvent(ev[6]), .alarmStopEvent(ev[7]), .sharedStopEvent(ev[8]),
    .emergencyStopEvent(ev[9]), .slowdownStopEvent(ev[10]), .partnerAxisErrorEvent(ev[13]),
    .pulserOverflowEvent(ev[14]), .interpOverrangeEvent(ev[15]),
    .encoderPhaseErrorEvent(ev[16]), .pulserPhaseErrorEvent(ev[17]), .startCommand,
    .operationTypeCode, .interpAxisCount, .arcCenterZero, .interpLengthZero,
    .fourthAxisNoResponse, .fourthAxisEarlyDone, .interpDataError, .causePending);
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input [31:0] seen, input [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim;
    if (mismatches == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one access; e pulses the event inputs at the taking edge
  task automatic bus(input bit w, input [3:0] a, input [31:0] wd, input [17:0] e);
    logic [31:0] x;
    x = a == 4'h0 ? {10'h000, opPreregOccupancy, cmp5PreregOccupancy, 1'b0, on,
      directionFlag, operationState} : a == 4'h1 ? m : a == 4'h2 ? {31'h0, mode} : 32'h0;
    @(posedge clk);
    addr <= a;
    wrData <= wd;
    wrStrobe <= w;
    rdStrobe <= !w;
    ev <= e;
    @(posedge clk);
    wrStrobe <= 0;
    rdStrobe <= 0;
    ev <= 0;
    if (a == 4'h1 && (w || !mode)) m = m & ~(w ? wd : 32'hFFFFFFFF);
    if (w && a == 4'h2) mode = wd[0];
    m = m | (e & 32'h0003E7FF);
    #1 if (!w) chk(rdData, x, "read data");
    chk(causePending, |m, "pending");
  endtask
  task automatic go(input [7:0] c, input [2:0] n, input z, input l);
    bit x;
    x = c inside {8'h60, 8'h61, 8'h68, 8'h69} && n == 3'h1 || l && c inside {8'h62,
      8'h63, 8'h6A, 8'h6B} || c inside {[8'h64:8'h67], 8'h6C, 8'h6D} && (n != 3'h2 || z);
    @(posedge clk);
    startCommand <= 1;
    operationTypeCode <= c;
    interpAxisCount <= n;
    arcCenterZero <= z;
    interpLengthZero <= l;
    #1 chk(interpDataError, x, "data error");
    @(posedge clk);
    startCommand <= 0;
    if (x) m[12] = 1;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    mismatches++;
    end_sim;
  end
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1;
    bus(0, 4'h2, 0, 0);
    bus(0, 4'h1, 0, 0);
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      operationState <= i[3:0];
      directionFlag <= $random(seed);
      cmp5PreregOccupancy <= $random(seed);
      opPreregOccupancy <= $random(seed);
      on <= $random(seed);
      repeat (6) @(posedge clk);
      bus(1, 4'h0, 32'hFFFFFFFF, 0);
      bus(0, 4'h0, 0, 0);
    end
    bus(0, 4'h5, 0, 0);
    for (i = 0; i < 24; i++) begin
      if (i == 12) bus(1, 4'h2, 32'h1, 0);
      bus(1, 4'h1, $random(seed), $random(seed));
      bus(0, 4'h1, 0, $random(seed));
      bus(0, 4'h1, 0, 0);
    end
    for (i = 0; i < 64; i++) go(8'h60 + i[3:0], i[5:4] + 3'h1, $random(seed), $random(seed));
    operationState <= 4'hB;
    go(8'h66, 3'h2, 0, 0);
    for (i = 0; i < 2; i++) begin
      @(posedge clk);
      {fourthAxisNoResponse, fourthAxisEarlyDone} <= 2'h1 << i;
      #1 chk(interpDataError, 1, "sync error");
      @(posedge clk);
      {fourthAxisNoResponse, fourthAxisEarlyDone} <= 2'h0;
      m[12] = 1;
    end
    operationState <= 4'h0;
    @(posedge clk);
    @(posedge clk);
    fourthAxisNoResponse <= 1;
    #1 chk(interpDataError, 0, "sync ended");
    @(posedge clk);
    fourthAxisNoResponse <= 0;
    bus(0, 4'h1, 0, 0);
    end_sim;
  end
endmodule // axis_status_error_cause_bench
